// ---- include/cap_params.svh ----
// constants for the command/address parity checker
// Notes on behaviour
// - a three-bit latency field enables checking; cleared at reset; any non-zero code enables
// - codes 000 off, 001 four, 010 five, 011 six, 100 eight clocks
// - with parity on, every command executes only after the parity latency
// - parity covers act, ras, cas, we, address, bank, group, chip id
// - unused address inputs enter parity as zero
// - even parity over covered inputs plus the parity input
// - a selected command with bad parity is discarded
// - failing command is logged; first log held until status clears
// - error status set to one before the alert is released
// - alert output driven low promptly after a bad command
// - drain, wait minimum row time, close all rows; no commands meanwhile
// - release alert only after minimum width and banks precharged
// - non-persistent mode: no checking until status bit written zero
// - latency write-only, status read/write, log read-only; writing one blocked
// - persistent mode resumes checking after alert, width within min and max
// - error log readable only when the log readout bit is set
`ifndef CAP_PARAMS_SVH
`define CAP_PARAMS_SVH

`define CAP_OFF_CTRL      8'h00
`define CAP_OFF_STATUS    8'h04
`define CAP_OFF_LOG_ADDR  8'h08
`define CAP_OFF_LOG_CMD   8'h0c

`define CAP_CTRL_PL_LSB   0
`define CAP_CTRL_LOGEN    3
`define CAP_CTRL_CID_LSB  4
`define CAP_CTRL_A17      7
`define CAP_CTRL_PERSIST  9
`define CAP_STAT_CHK      0
`define CAP_STAT_ERR      4
`define CAP_STAT_ALERT    8

`define CAP_PL_RST        3'h0
`define CAP_CID_RST       3'h0
`define CAP_PL_T1         4'h4
`define CAP_PL_T2         4'h5
`define CAP_PL_T3         4'h6
`define CAP_PL_MAX        8

`define CAP_TRAS_MIN_CK   5'd8
`define CAP_ALERT_PW_MIN  5'd12
`define CAP_ALERT_PW_MAX  5'd24

`endif

// ---- include/cap_pkg.sv ----
// types and latency decode for the command/address parity checker
`include "cap_params.svh"
package cap_pkg;
	typedef logic [29:0] cap_cmd_t;
	typedef enum logic [1:0] {CAP_IDLE, CAP_DRAIN, CAP_HOLD} cap_state_t;

	// latency code to clock count; reserved codes above 100 take the longest
	function automatic logic [3:0] cap_pl_ticks(input logic [2:0] code);
		case (code)
			3'h0: cap_pl_ticks = 4'h0;
			3'h1: cap_pl_ticks = `CAP_PL_T1;
			3'h2: cap_pl_ticks = `CAP_PL_T2;
			3'h3: cap_pl_ticks = `CAP_PL_T3;
			default: cap_pl_ticks = 4'(`CAP_PL_MAX);
		endcase
	endfunction
endpackage

// ---- rtl/cap_sync.sv ----
// two-flop synchroniser for pins from the link domain
module cap_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// ---- rtl/cap_delay.sv ----
// command delay line, taps selected by the parity latency in link clocks
`include "cap_params.svh"
module cap_delay (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// link clock tick and tap select
	input  wire logic        en,
	input  wire logic [3:0]  sel,
	// valid bit over command word
	input  wire logic [30:0] din,
	output logic      [30:0] dout
);
	logic [30:0] sr_q [`CAP_PL_MAX];
	logic [30:0] sr_d [`CAP_PL_MAX];

	genvar i;
	generate
		for (i = 0; i < `CAP_PL_MAX; i++) begin : g_stage
			if (i == 0) begin : g_first
				always_comb sr_d[i] = en ? din : sr_q[i];
			end else begin : g_next
				always_comb sr_d[i] = en ? sr_q[i-1] : sr_q[i];
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) sr_q[i] <= '0;
				else sr_q[i] <= sr_d[i];
			end
		end
	endgenerate

	always_comb begin
		if (sel == 4'h0) dout = din;
		else dout = sr_q[3'(sel - 4'h1)];
	end
endmodule

// ---- rtl/cap_checker.sv ----
// command/address parity checker with alert, error log and apb registers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`include "cap_params.svh"
module cap_checker (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// command/address pins
	input  wire logic              ck,
	input  wire logic              cs_n,
	input  wire logic              act_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic [17:0]       addr,
	input  wire logic [1:0]        bg,
	input  wire logic [1:0]        ba,
	input  wire logic [2:0]        cid,
	input  wire logic              par,
	input  wire logic              srx_busy,
	// alert and command execution
	output logic                   alert_n,
	output logic                   exec_valid,
	output cap_pkg::cap_cmd_t      exec_cmd,
	output logic                   pre_all
);
	import cap_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// pin synchronisation and link clock edge
	logic [32:0] s_raw;
	logic [32:0] s_q;
	logic        ck_d_q;
	logic        ck_rise;
	logic        cs_n_s;
	logic        srx_s;
	cap_cmd_t    cmd_raw;

	assign s_raw = {ck, cs_n, act_n, ras_n, cas_n, we_n, addr, bg, ba, cid, par, srx_busy};

	cap_sync #(.W(33)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (s_raw),
		.q     (s_q)
	);

	assign cs_n_s  = s_q[31];
	assign cmd_raw = s_q[30:1];
	assign srx_s   = s_q[0];
	assign ck_rise = s_q[32] & ~ck_d_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ck_d_q <= 1'b0;
		else ck_d_q <= s_q[32];
	end

	// configuration, status and log state
	logic [2:0]  pl_code_q, pl_code_d;
	logic        persist_q, persist_d;
	logic        log_en_q, log_en_d;
	logic [2:0]  cid_used_q, cid_used_d;
	logic        a17_used_q, a17_used_d;
	logic        err_q, err_d;
	cap_cmd_t    log_q, log_d;
	logic [31:0] prdata_q, prdata_d;

	// checker state
	cap_state_t  st_q, st_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        alert_n_q, alert_n_d;
	logic        pre_all_q, pre_all_d;
	logic        exec_valid_q, exec_valid_d;
	cap_cmd_t    exec_cmd_q, exec_cmd_d;

	logic [3:0]  pl_ticks;
	logic        pl_en;
	logic        chk_on;
	logic        selected;
	logic        bad;
	logic        push;
	cap_cmd_t    cmd_m;
	logic [30:0] dly_out;
	logic        wr;
	logic        rd_setup;
	logic        mapped;

	assign pl_ticks = cap_pl_ticks(pl_code_q);
	assign pl_en    = pl_ticks != 4'h0;
	// unused stacking and high address pins count as zero
	assign cmd_m = cmd_raw & {4'hf, a17_used_q, 17'h1ffff, 4'hf, cid_used_q, 1'b1};
	assign selected = ck_rise & ~cs_n_s;
	assign chk_on   = pl_en & (~err_q | persist_q) & (st_q == CAP_IDLE);
	assign bad      = selected & chk_on & (^cmd_m);
	assign push     = selected & (st_q == CAP_IDLE) & ~bad;

	cap_delay u_dly (
		.clk   (pclk),
		.rst_n (presetn),
		.en    (ck_rise),
		.sel   (pl_ticks),
		.din   ({push, cmd_m}),
		.dout  (dly_out)
	);

	// apb decode
	assign wr       = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign mapped   = hit(paddr, `CAP_OFF_CTRL) | hit(paddr, `CAP_OFF_STATUS) |
		hit(paddr, `CAP_OFF_LOG_ADDR) | hit(paddr, `CAP_OFF_LOG_CMD);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped;

	always_comb begin
		pl_code_d  = pl_code_q;
		persist_d  = persist_q;
		log_en_d   = log_en_q;
		cid_used_d = cid_used_q;
		a17_used_d = a17_used_q;
		err_d      = err_q;
		log_d      = log_q;
		prdata_d   = prdata_q;
		if (wr && hit(paddr, `CAP_OFF_CTRL)) begin
			pl_code_d  = pwdata[`CAP_CTRL_PL_LSB +: 3];
			log_en_d   = pwdata[`CAP_CTRL_LOGEN];
			cid_used_d = pwdata[`CAP_CTRL_CID_LSB +: 3];
			a17_used_d = pwdata[`CAP_CTRL_A17];
			persist_d  = pwdata[`CAP_CTRL_PERSIST];
		end
		// only a zero is taken; a written one is blocked
		if (wr && hit(paddr, `CAP_OFF_STATUS) && !pwdata[`CAP_STAT_ERR]) begin
			err_d = 1'b0;
		end
		// a new error wins over a clear in the same cycle
		if (bad) begin
			err_d = 1'b1;
		end
		if (bad && !err_q) begin
			log_d = cmd_m;
		end
		if (rd_setup) begin
			prdata_d = 32'h0;
			if (hit(paddr, `CAP_OFF_CTRL)) begin
				prdata_d[`CAP_CTRL_LOGEN]        = log_en_q;
				prdata_d[`CAP_CTRL_CID_LSB +: 3] = cid_used_q;
				prdata_d[`CAP_CTRL_A17]          = a17_used_q;
				prdata_d[`CAP_CTRL_PERSIST]      = persist_q;
			end
			if (hit(paddr, `CAP_OFF_STATUS)) begin
				prdata_d[`CAP_STAT_CHK]   = chk_on;
				prdata_d[`CAP_STAT_ERR]   = err_q;
				prdata_d[`CAP_STAT_ALERT] = ~alert_n_q;
			end
			if (hit(paddr, `CAP_OFF_LOG_ADDR) && log_en_q) begin
				prdata_d[17:0] = log_q[25:8];
			end
			if (hit(paddr, `CAP_OFF_LOG_CMD) && log_en_q) begin
				prdata_d[11:0] = {log_q[29:26], log_q[7:0]};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pl_code_q  <= `CAP_PL_RST;
			persist_q  <= 1'b0;
			log_en_q   <= 1'b0;
			cid_used_q <= `CAP_CID_RST;
			a17_used_q <= 1'b0;
			err_q      <= 1'b0;
			log_q      <= '0;
			prdata_q   <= 32'h0;
		end else begin
			pl_code_q  <= pl_code_d;
			persist_q  <= persist_d;
			log_en_q   <= log_en_d;
			cid_used_q <= cid_used_d;
			a17_used_q <= a17_used_d;
			err_q      <= err_d;
			log_q      <= log_d;
			prdata_q   <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	// alert sequence and delayed execution
	always_comb begin
		st_d         = st_q;
		cnt_d        = cnt_q;
		pre_all_d    = 1'b0;
		exec_valid_d = ck_rise & dly_out[30];
		exec_cmd_d   = exec_valid_d ? dly_out[29:0] : exec_cmd_q;
		unique case (st_q)
			CAP_IDLE: begin
				if (bad) begin
					st_d  = CAP_DRAIN;
					cnt_d = 5'd0;
				end
			end
			CAP_DRAIN: begin
				if (ck_rise) begin
					cnt_d = cnt_q + 5'd1;
					if (cnt_q == `CAP_TRAS_MIN_CK) begin
						pre_all_d = 1'b1;
						st_d      = CAP_HOLD;
					end
				end
			end
			CAP_HOLD: begin
				if (ck_rise) begin
					if (cnt_q != 5'h1f) cnt_d = cnt_q + 5'd1;
					// self-refresh exit work may stretch the alert
					if (cnt_q >= `CAP_ALERT_PW_MIN &&
						(!srx_s || (persist_q && cnt_q >= `CAP_ALERT_PW_MAX))) begin
						st_d = CAP_IDLE;
					end
				end
			end
		endcase
		alert_n_d = (st_d == CAP_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q         <= CAP_IDLE;
			cnt_q        <= 5'd0;
			alert_n_q    <= 1'b1;
			pre_all_q    <= 1'b0;
			exec_valid_q <= 1'b0;
			exec_cmd_q   <= '0;
		end else begin
			st_q         <= st_d;
			cnt_q        <= cnt_d;
			alert_n_q    <= alert_n_d;
			pre_all_q    <= pre_all_d;
			exec_valid_q <= exec_valid_d;
			exec_cmd_q   <= exec_cmd_d;
		end
	end

	assign alert_n    = alert_n_q;
	assign pre_all    = pre_all_q;
	assign exec_valid = exec_valid_q;
	assign exec_cmd   = exec_cmd_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_OFF_NO_ERROR: assert property (
		pl_code_q == 3'h0 |-> !bad) else $error("error flagged with parity off");
	AST_ALERT_LOW: assert property (
		bad |=> !alert_n ##1 !alert_n) else $error("alert not driven low after error");
	AST_STATUS_SET: assert property (
		$rose(alert_n) |-> err_q || persist_q) else $error("alert released with clear status");
	AST_DISCARD: assert property (
		bad |-> !push) else $error("bad command queued for execution");
	AST_LOG_HOLD: assert property (
		err_q ##1 err_q |-> $stable(log_q)) else $error("log changed while status set");
	AST_PRECHARGE: assert property (
		pre_all |-> $past(cnt_q) == `CAP_TRAS_MIN_CK && !alert_n) else $error("precharge mistimed");
	AST_NO_ACCEPT: assert property (
		st_q != CAP_IDLE |-> !push) else $error("command accepted during alert");
	AST_RELEASE: assert property (
		$rose(alert_n) |-> $past(cnt_q) >= `CAP_ALERT_PW_MIN) else $error("alert pulse too short");
	AST_NO_CHECK: assert property (
		err_q && !persist_q |-> !bad) else $error("checking while status set");
	AST_BLOCK_ONE: assert property (
		!err_q && !bad && wr && hit(paddr, `CAP_OFF_STATUS) |=> !err_q)
		else $error("status bit set by software");
	AST_LOG_GATE: assert property (
		rd_setup && !log_en_q && hit(paddr, `CAP_OFF_LOG_ADDR) |=> prdata == 32'h0)
		else $error("log readable while readout disabled");
endmodule

// ---- verif/cap_ctl_model.sv ----
// controller-side model: makes the link clock and drives one command per request
module cap_ctl_model (
	// request from the bench
	input  wire logic              req,
	input  wire cap_pkg::cap_cmd_t cmd,
	// link pins, and the sent toggle back to the bench
	output logic                   ck,
	output logic                   cs_n,
	output logic [29:0]            bus,
	output logic                   sent
);
	timeunit 1ns;
	timeprecision 1ns;
	import cap_pkg::*;

	// free-running link clock, phase unrelated to the system clock
	initial begin
		ck = 1'b0;
		cs_n = 1'b1;
		bus = '0;
		sent = 1'b0;
		#7;
		forever #160 ck = ~ck;
	end

	// launch on the falling edge so lines are settled at the sampling edge
	always @(negedge ck) begin
		if (req) begin
			cs_n <= 1'b0;
			bus <= cmd;
			sent <= ~sent;
		end else begin
			// deselect; lines toggle each tick between the inverse of the old command and the old command
			cs_n <= 1'b1;
			bus <= ~bus;
		end
	end
endmodule

// ---- verif/cap_checker_tb.sv ----
// self-checking bench for the command/address parity checker
`include "cap_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module cap_checker_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cap_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic        ck, cs_n, srx_busy, alert_n, exec_valid, pre_all, req, sent;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [29:0] cab;
	cap_cmd_t    cmd, exec_cmd;
	int          mismatches = 0, checked = 0, cyc = 0, ckn = 0, nex = 0, npre = 0, aw = 0;
	int          t0, got;

	cap_checker cap_checker_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ck(ck), .cs_n(cs_n), .act_n(cab[29]), .ras_n(cab[28]), .cas_n(cab[27]), .we_n(cab[26]),
		.addr(cab[25:8]), .bg(cab[7:6]), .ba(cab[5:4]), .cid(cab[3:1]), .par(cab[0]),
		.srx_busy(srx_busy), .alert_n(alert_n), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
		.pre_all(pre_all)
	);
	cap_ctl_model cap_ctl_model_inst (.req(req), .cmd(cmd), .ck(ck), .cs_n(cs_n), .bus(cab),
		.sent(sent));

	always #20 pclk = ~pclk;
	always @(posedge ck) ckn <= ckn + 1;
	// event counters and the hang limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		nex <= nex + int'(exec_valid === 1'b1);
		npre <= npre + int'(pre_all === 1'b1);
		aw <= aw + int'(alert_n === 1'b0);
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// command word with even parity; unused address bit 17 stays out of it
	function automatic cap_cmd_t mk(input logic [17:0] a, input logic bad);
		cap_cmd_t c;
		c = {4'h5, a, 2'h1, 2'h2, 3'h0, 1'b0};
		c[0] = ^c[29:1] ^ c[25] ^ bad;
		return c;
	endfunction

	// waits for ready as long as it takes; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// control write, then the settle time around parity entry and exit
	task automatic mode(input logic [31:0] d);
		apb(1'b1, `CAP_OFF_CTRL, d);
		repeat (96) @(posedge pclk);
	endtask

	task automatic send(input cap_cmd_t c);
		logic s;
		s = sent;
		cmd <= c;
		req <= 1'b1;
		while (sent === s) begin
			@(posedge pclk);
		end
		req <= 1'b0;
		t0 = ckn;
	endtask

	// wait for a level; the cycle ceiling ends a hang; got is link ticks since the command
	task automatic wait_on(ref logic s, input logic v);
		while (s !== v) begin
			@(posedge pclk);
		end
		got = ckn - t0;
	endtask

	task automatic t_reset();
		`CHK("alert_idle", 1'b1, alert_n)
		`CHK("ready", 1'b1, pready)
		apb(1'b0, `CAP_OFF_STATUS, 32'h0);
		`CHK("status_rst", 32'h0, rdat)
		send(mk(18'h00321, 1'b1));
		wait_on(exec_valid, 1'b1);
		`CHK("off_ticks", 1, got)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, rerr)
		`CHK("off_alert", 1'b1, alert_n)
	endtask

	task automatic t_pl();
		int tk[5] = '{0, 4, 5, 6, 8};
		cap_cmd_t c;
		for (int i = 1; i < 5; i++) begin
			mode(32'h0);
			mode(32'(i));
			apb(1'b0, `CAP_OFF_CTRL, 32'h0);
			`CHK("pl_wo", 3'h0, rdat[2:0])
			apb(1'b0, `CAP_OFF_STATUS, 32'h0);
			`CHK("chk_on", 1'b1, rdat[0])
			c = mk(18'h20000 + 18'(i), 1'b0);
			send(c);
			wait_on(exec_valid, 1'b1);
			`CHK("pl_ticks", tk[i] + 1, got)
			`CHK("exec_cmd", {c[29:26], 1'b0, c[24:0]}, exec_cmd)
		end
	endtask

	task automatic t_err();
		cap_cmd_t c;
		int e0, p0, a0;
		mode(32'h0);
		mode(32'h9);
		c = mk(18'h0abcd, 1'b1);
		e0 = nex;
		p0 = npre;
		a0 = aw;
		send(c);
		wait_on(alert_n, 1'b0);
		`CHK("alert_at", 1, got)
		apb(1'b0, `CAP_OFF_STATUS, 32'h0);
		`CHK("stat_err", 32'h110, rdat & 32'h110)
		apb(1'b0, `CAP_OFF_LOG_ADDR, 32'h0);
		`CHK("log_addr", 18'h0abcd, rdat[17:0])
		apb(1'b0, `CAP_OFF_LOG_CMD, 32'h0);
		`CHK("log_cmd", {c[29:26], c[7:0]}, rdat[11:0])
		wait_on(alert_n, 1'b1);
		`CHK("alert_w", (`CAP_ALERT_PW_MIN + 1) * 8, aw - a0)
		`CHK("dropped", e0, nex)
		`CHK("precharge", p0 + 1, npre)
		send(mk(18'h00123, 1'b1));
		wait_on(exec_valid, 1'b1);
		`CHK("unchecked", 5, got)
		`CHK("no_alert", 1'b1, alert_n)
		mode(32'h1);
		apb(1'b0, `CAP_OFF_LOG_ADDR, 32'h0);
		`CHK("log_hidden", 32'h0, rdat)
		apb(1'b1, `CAP_OFF_STATUS, 32'h0);
		apb(1'b1, `CAP_OFF_STATUS, 32'h10);
		apb(1'b0, `CAP_OFF_STATUS, 32'h0);
		`CHK("err_clear", 1'b0, rdat[4])
	endtask

	// every mask bit in use, a chip id flip, then the extra refresh after the error
	task automatic t_mask();
		cap_cmd_t c;
		mode(32'h0);
		mode(32'hf1);
		c = mk(18'h20001, 1'b0);
		c[3:1] = 3'h5;
		c[0] = ^c[29:1];
		send(c);
		wait_on(exec_valid, 1'b1);
		`CHK("mask_all", c, exec_cmd)
		c[2] = ~c[2];
		send(c);
		wait_on(alert_n, 1'b0);
		`CHK("cid_par", 1, got)
		wait_on(alert_n, 1'b1);
		c = {4'h9, 26'h0};
		send(c);
		wait_on(exec_valid, 1'b1);
		`CHK("refresh", c, exec_cmd)
		apb(1'b1, `CAP_OFF_STATUS, 32'h0);
	endtask

	task automatic t_persist();
		int a0;
		mode(32'h0);
		mode(32'h201);
		srx_busy <= 1'b1;
		a0 = aw;
		send(mk(18'h00055, 1'b1));
		wait_on(alert_n, 1'b0);
		wait_on(alert_n, 1'b1);
		`CHK("alert_max", (`CAP_ALERT_PW_MAX + 1) * 8, aw - a0)
		srx_busy <= 1'b0;
		send(mk(18'h00066, 1'b1));
		wait_on(alert_n, 1'b0);
		`CHK("persist", 1, got)
		wait_on(alert_n, 1'b1);
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, req, srx_busy} = '0;
		paddr = 8'h0;
		pwdata = 32'h0;
		cmd = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_pl();
		t_err();
		t_mask();
		t_persist();
		end_of_test();
	end
endmodule
